//--- sda_regs.svh
// offsets, field positions, reset values and counts for the dma arbiter
// Notes on behaviour
// RULE1: take requests from six sources; a priority encoder picks one.
// RULE2: requests arriving while busy wait until all higher ones are served.
// RULE3: fixed order video, sound, telecom, highway channel, uart a, uart b.
// RULE4: one start pulse with read or write flag per transaction.
// RULE5: selected channel address and data are routed to memory.
// RULE6: one longword per transaction; video moves four, four acknowledges.
// RULE7: uart moves one byte, lane chosen by its address byte count.
// RULE8: an acknowledge goes to the selected source at each transfer end.
// RULE9: source latches read data or supplies write data on acknowledge.
// RULE10: test enable, untimed test, forced request vector; reset to zero.
// RULE11: six address bits, select and direction give one of 64 enables.
// RULE12: write enable makes register capture, read enable makes it drive.
// RULE13: offsets are decoded relative to the register base address.
// RULE14: read and write at one offset reach different registers; the test register at offset 0x1C8 is read and written as one register.
// RULE15: source holds its request until the acknowledge ending it.
`ifndef SDA_REGS_SVH
`define SDA_REGS_SVH

`define SDA_BASE_ADDR 32'h10C00000
`define SDA_SPAN 32'h00000200
`define SDA_TEST_OFS 32'h000001C8
`define SDA_TEST_EN_BIT 7
`define SDA_UNTIMED_BIT 6
`define SDA_FORCE_MSB 5
`define SDA_TEST_RST 8'h00
`define SDA_NUM_SRC 6
`define SDA_CH_VIDEO 3'h0
`define SDA_CH_UARTA 3'h4
`define SDA_CH_UARTB 3'h5
`define SDA_VIDEO_LAST 2'h3
`define SDA_RD_MASK 64'hFFFFFFFFFFFFFFFF
`define SDA_WR_MASK 64'hFFFFFFFFFFFFFFFF

`endif

//--- sda_pkg.sv
// types shared by the dma arbiter and its buffer
package sda_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic wr;
    } sda_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT
    } sda_state_t;
endpackage

//--- sda_stream_if.sv
// valid/ready carrier for memory commands
`timescale 1ns/1ns
interface sda_stream_if;
    import sda_pkg::*;
    logic valid;
    logic ready;
    sda_cmd_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- sda_buf.sv
// two-entry command buffer between the arbiter and memory
`timescale 1ns/1ns
module sda_buf
    import sda_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    sda_stream_if.snk in_s,
    sda_stream_if.src out_s
);
    logic head_valid;
    logic tail_valid;
    sda_cmd_t head;
    sda_cmd_t tail;
    logic push;
    logic pop;
    logic head_free;

    // ready looks only at the tail flag so the source never sees a loop
    assign in_s.ready = !tail_valid;
    assign out_s.valid = head_valid;
    assign out_s.data = head;
    assign push = in_s.valid && !tail_valid;
    assign pop = head_valid && out_s.ready;
    assign head_free = !head_valid || pop;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            head_valid <= 1'b0;
            tail_valid <= 1'b0;
            head <= '0;
            tail <= '0;
        end else if (head_free) begin
            if (tail_valid) begin
                head <= tail;
                head_valid <= 1'b1;
                tail_valid <= push;
                if (push) begin
                    tail <= in_s.data;
                end
            end else begin
                head_valid <= push;
                if (push) begin
                    head <= in_s.data;
                end
            end
        end else if (push) begin
            tail <= in_s.data;
            tail_valid <= 1'b1;
        end
    end
endmodule

//--- sda_siu.sv
// dma arbiter and register address decoder of the system interface unit
`timescale 1ns/1ns
`include "sda_regs.svh"
module sda_siu
    import sda_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [5:0] i_dma_req,
    input wire logic [5:0] i_dma_wr,
    input wire logic [5:0][31:0] i_src_addr,
    input wire logic [5:0][31:0] i_src_wdata,
    output logic [5:0] o_dma_ack,
    output logic [31:0] o_src_rdata,
    output logic o_cpu_start,
    output logic o_cpu_write,
    output logic o_mem_valid,
    input wire logic i_mem_ready,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    output logic [3:0] o_mem_be,
    output logic o_mem_wr,
    input wire logic i_mem_done,
    input wire logic [31:0] i_mem_rdata,
    input wire logic i_reg_cs,
    input wire logic i_reg_wr,
    input wire logic [31:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [63:0] o_reg_wen,
    output logic [63:0] o_reg_ren,
    output logic [31:0] o_reg_rdata
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [63:0] one_hot(input logic [5:0] idx);
        logic [63:0] v;
        v = 64'h0;
        v[idx] = 1'b1;
        return v;
    endfunction

    // lowest index wins: video is bit 0, uart b bit 5
    function automatic logic [2:0] pick(input logic [5:0] req);
        logic [2:0] r;
        r = 3'h0;
        for (int i = `SDA_NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // ****************************************
    // test register
    // ****************************************
    logic [7:0] test_ctl;
    logic [31:0] offset;
    logic in_window;
    logic test_hit;

    assign offset = i_reg_addr - `SDA_BASE_ADDR; // RULE13
    assign in_window = i_reg_cs && (offset < `SDA_SPAN);
    assign test_hit = in_window && (offset == `SDA_TEST_OFS);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            test_ctl <= `SDA_TEST_RST; // RULE10
        end else if (test_hit && i_reg_wr) begin
            test_ctl <= i_reg_wdata[7:0]; // RULE12
        end
    end

    // ****************************************
    // register enable decoder
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_wen <= 64'h0;
            o_reg_ren <= 64'h0;
        end else if (in_window) begin
            // only offset bits 7:2 decode, so 0x000 and 0x100 share an enable
            // RULE11 RULE14
            o_reg_wen <= i_reg_wr ?
                one_hot(offset[7:2]) & `SDA_WR_MASK : 64'h0;
            o_reg_ren <= !i_reg_wr ?
                one_hot(offset[7:2]) & `SDA_RD_MASK : 64'h0;
        end else begin
            o_reg_wen <= 64'h0;
            o_reg_ren <= 64'h0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 32'h0;
        end else if (test_hit && !i_reg_wr) begin
            o_reg_rdata <= {24'h0, test_ctl}; // RULE12
        end else begin
            o_reg_rdata <= 32'h0;
        end
    end

    // ****************************************
    // arbitration state machine
    // ****************************************
    sda_stream_if cmd_in ();
    sda_stream_if cmd_out ();

    sda_buf u_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .in_s(cmd_in.snk),
        .out_s(cmd_out.src)
    );

    sda_state_t state;
    logic [2:0] chan;
    logic [1:0] beat;
    logic [5:0] eff_req;
    logic pushed;
    logic done;
    logic last;
    logic [31:0] sel_addr;
    logic can_pick;

    // forced vector replaces the real requests while test mode is on
    assign eff_req = test_ctl[`SDA_TEST_EN_BIT] ?
        test_ctl[`SDA_FORCE_MSB:0] : i_dma_req; // RULE10 RULE1
    assign pushed = cmd_in.valid && cmd_in.ready;
    // the ack is registered, so a source can only drop its request on the
    // edge that shows the ack; picking then would serve it a second time
    assign can_pick = (state == ST_IDLE) && (|eff_req) &&
        (o_dma_ack == 6'h0); // RULE2
    // untimed test ends a transfer as soon as the buffer takes it
    assign done = test_ctl[`SDA_UNTIMED_BIT] ?
        (state == ST_WAIT) : (state == ST_WAIT) && i_mem_done;
    assign last = (chan != `SDA_CH_VIDEO) || (beat == `SDA_VIDEO_LAST);
    assign sel_addr = i_src_addr[chan];

    always_comb begin
        cmd_in.valid = (state == ST_ISSUE);
        // RULE5 RULE6
        cmd_in.data.addr = {sel_addr[31:4], beat, sel_addr[1:0]};
        if (chan != `SDA_CH_VIDEO) begin
            cmd_in.data.addr = sel_addr;
        end
        cmd_in.data.wdata = i_src_wdata[chan];
        cmd_in.data.wr = i_dma_wr[chan];
        cmd_in.data.be = 4'hF;
        if (chan == `SDA_CH_UARTA || chan == `SDA_CH_UARTB) begin
            cmd_in.data.be = 4'h1 << sel_addr[1:0]; // RULE7
        end
    end

    assign cmd_out.ready = i_mem_ready;
    assign o_mem_valid = cmd_out.valid;
    assign o_mem_addr = cmd_out.data.addr;
    assign o_mem_wdata = cmd_out.data.wdata;
    assign o_mem_be = cmd_out.data.be;
    assign o_mem_wr = cmd_out.data.wr;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            chan <= 3'h0;
            beat <= 2'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // lower requests stay pending until served
                    if (can_pick) begin
                        chan <= pick(eff_req); // RULE1 RULE2 RULE3
                        beat <= 2'h0;
                        state <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    if (pushed) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (done) begin
                        beat <= beat + 2'h1;
                        state <= last ? ST_IDLE : ST_ISSUE; // RULE6
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cpu_start <= 1'b0;
            o_cpu_write <= 1'b0;
        end else begin
            o_cpu_start <= can_pick; // RULE4
            // direction holds until the next start so it can be read late
            if (can_pick) begin
                o_cpu_write <= i_dma_wr[pick(eff_req)]; // RULE4
            end
        end
    end

    // ack pulse and read data land together so the source can latch
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dma_ack <= 6'h0;
            o_src_rdata <= 32'h0;
        end else begin
            o_dma_ack <= done ? 6'(6'h1 << chan) : 6'h0; // RULE8 RULE9
            if (done) begin
                o_src_rdata <= i_mem_rdata;
            end
        end
    end
endmodule

//--- sda_siu_assertions.sv
// port checker for the dma arbiter and register decoder
`timescale 1ns/1ns
module sda_siu_assertions (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [5:0] o_dma_ack,
    input wire logic o_cpu_start,
    input wire logic o_mem_valid,
    input wire logic i_mem_ready,
    input wire logic [31:0] o_mem_addr,
    input wire logic [3:0] o_mem_be,
    input wire logic i_reg_cs,
    input wire logic i_reg_wr,
    input wire logic [31:0] i_reg_addr,
    input wire logic [63:0] o_reg_wen,
    input wire logic [63:0] o_reg_ren
);
    // ********
    // properties
    // ********
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [31:0] ofs;
    logic [5:0] idx;
    assign ofs = i_reg_addr - 32'h10C00000;
    assign idx = ofs[7:2];
    property p_start; o_cpu_start |=> !o_cpu_start; endproperty
    a_start: assert property (p_start) else $error("start too long");
    property p_ack1; $onehot0(o_dma_ack); endproperty
    a_ack1: assert property (p_ack1) else $error("two acks");
    property p_ackt; o_cpu_start |-> ##[1:60] o_dma_ack != 6'h0; endproperty
    a_ackt: assert property (p_ackt) else $error("no ack");
    property p_gap; o_dma_ack != 6'h0 |=> !o_cpu_start; endproperty
    a_gap: assert property (p_gap) else $error("served twice");
    property p_wen;
        i_reg_cs && i_reg_wr && ofs < 32'h200 |=>
            o_reg_wen == 64'h1 << $past(idx) && o_reg_ren == 64'h0;
    endproperty
    a_wen: assert property (p_wen) else $error("bad wen");
    property p_ren;
        i_reg_cs && !i_reg_wr && ofs < 32'h200 |=>
            o_reg_ren == 64'h1 << $past(idx) && o_reg_wen == 64'h0;
    endproperty
    a_ren: assert property (p_ren) else $error("bad ren");
    property p_out;
        i_reg_cs && ofs >= 32'h200 |=>
            o_reg_wen == 64'h0 && o_reg_ren == 64'h0;
    endproperty
    a_out: assert property (p_out) else $error("enable outside");
    property p_hold;
        o_mem_valid && !i_mem_ready |=> o_mem_valid && $stable(o_mem_addr);
    endproperty
    a_hold: assert property (p_hold) else $error("cmd dropped");
    property p_be;
        o_mem_valid |-> o_mem_be == 4'hF || $onehot(o_mem_be);
    endproperty
    a_be: assert property (p_be) else $error("bad lanes");
    c_video: cover property (o_dma_ack[0]);
    c_uart: cover property (o_dma_ack[5]);
    c_read: cover property (o_reg_ren[50]);
endmodule
bind sda_siu sda_siu_assertions chk_u (.i_clk, .i_rst, .o_dma_ack,
    .o_cpu_start, .o_mem_valid, .i_mem_ready, .o_mem_addr, .o_mem_be,
    .i_reg_cs, .i_reg_wr, .i_reg_addr, .o_reg_wen, .o_reg_ren);

//--- sda_mem_model.sv
// memory stand-in with stalls and delayed completion
`timescale 1ns/1ns
module sda_mem_model
    import sda_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire sda_cmd_t i_cmd,
    output logic o_ready,
    output logic o_done,
    output logic [31:0] o_rdata,
    output sda_cmd_t o_cap
);
    // ********
    // completion timing
    // ********
    logic [3:0] tick;
    logic [2:0] left;
    // ready drops on odd cycles so the buffer has to hold its head
    assign o_ready = !tick[0] && left == 3'h0 && !o_done;
    // off the done cycle the bus moves, so stale data cannot pass
    assign o_rdata = o_done ? {~o_cap.addr} : {8{tick}};
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick <= 4'h0;
            left <= 3'h0;
            o_done <= 1'h0;
            o_cap <= '0;
        end else begin
            tick <= tick + 4'h1;
            o_done <= left == 3'h1;
            if (left != 3'h0) begin
                left <= left - 3'h1;
            end else if (i_valid && o_ready) begin
                o_cap <= i_cmd;
                left <= tick[1] ? 3'h4 : 3'h1;
            end
        end
    end
endmodule

//--- tb.sv
// bench for the dma arbiter and register decoder
`timescale 1ns/1ns
module tb;
    import sda_pkg::*;
    localparam logic [31:0] TA = 32'h10C001C8;
    localparam logic [63:0] TE = 64'h0004000000000000;
    logic i_clk, i_rst, i_reg_cs, i_reg_wr, i_mem_ready, i_mem_done;
    logic o_cpu_start, o_cpu_write, o_mem_valid, o_mem_wr;
    logic [5:0] i_dma_req, i_dma_wr, o_dma_ack;
    logic [5:0][31:0] i_src_addr, i_src_wdata;
    logic [31:0] o_src_rdata, o_mem_addr, o_mem_wdata, i_mem_rdata;
    logic [31:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [63:0] o_reg_wen, o_reg_ren;
    logic [3:0] o_mem_be;
    logic [5:0] req_add, req_next;
    sda_cmd_t cap;
    int error_cnt = 0;
    int checked = 0;
    int starts = 0;
    int beat = 0;
    int exp_q[$];
    sda_siu dut_u (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_dma_req(i_dma_req),
        .i_dma_wr(i_dma_wr),
        .i_src_addr(i_src_addr),
        .i_src_wdata(i_src_wdata),
        .o_dma_ack(o_dma_ack),
        .o_src_rdata(o_src_rdata),
        .o_cpu_start(o_cpu_start),
        .o_cpu_write(o_cpu_write),
        .o_mem_valid(o_mem_valid),
        .i_mem_ready(i_mem_ready),
        .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata),
        .o_mem_be(o_mem_be),
        .o_mem_wr(o_mem_wr),
        .i_mem_done(i_mem_done),
        .i_mem_rdata(i_mem_rdata),
        .i_reg_cs(i_reg_cs),
        .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_wen(o_reg_wen),
        .o_reg_ren(o_reg_ren),
        .o_reg_rdata(o_reg_rdata)
    );
    sda_mem_model mem_u (.i_clk(i_clk), .i_rst(i_rst), .i_valid(o_mem_valid),
        .i_cmd({o_mem_addr, o_mem_wdata, o_mem_be, o_mem_wr}),
        .o_ready(i_mem_ready), .o_done(i_mem_done), .o_rdata(i_mem_rdata),
        .o_cap(cap));
    // ********
    // tasks
    // ********
    task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(logic wr, logic [31:0] a, logic [31:0] d,
                       logic [63:0] en, logic [31:0] rd);
        i_reg_cs <= 1'h1;
        i_reg_wr <= wr;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_cs <= 1'h0;
        #1;
        cmp("wen", wr ? en : 64'h0, o_reg_wen);
        cmp("ren", wr ? 64'h0 : en, o_reg_ren);
        cmp("rdata", rd, o_reg_rdata);
        @(posedge i_clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // sources drop the request only after seeing their final ack
    always @(posedge i_clk) begin
        if (o_cpu_start === 1'h1) starts++;
        req_next = i_rst ? 6'h00 : i_dma_req | req_add;
        for (int s = 0; s < 6; s++) begin
            if (o_dma_ack[s] === 1'h1) begin
                cmp("src", exp_q.pop_front(), s);
                cmp("addr", s != 0 ? i_src_addr[s] :
                    {i_src_addr[0][31:4], beat[1:0], 2'h0}, cap.addr);
                cmp("be", s > 3 ? 4'h1 << i_src_addr[s][1:0] : 4'hF,
                    cap.be);
                cmp("wr", i_dma_wr[s], cap.wr);
                cmp("data", i_dma_wr[s] ? i_src_wdata[s] : {~cap.addr},
                    i_dma_wr[s] ? cap.wdata : o_src_rdata);
                cmp("cpu_wr", i_dma_wr[s], o_cpu_write);
                beat = s == 0 ? beat + 1 : 0;
                if (s != 0 || beat == 4) req_next[s] = 1'h0;
            end
        end
        i_dma_req <= req_next;
    end
    initial begin
        i_clk = 1'h0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        #100000;
        error_cnt++;
        test_done();
    end
    initial begin
        i_rst = 1'h1;
        {i_reg_cs, i_reg_wr, i_reg_addr, i_reg_wdata} = '0;
        req_add = 6'h00;
        i_dma_wr = 6'h2A;
        i_src_addr = {32'h3003, 32'h2001, 32'h4000, 32'h5000, 32'h6000,
            32'h1000};
        i_src_wdata = ~i_src_addr;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'h0;
        @(posedge i_clk);
        acc(1'h0, TA, 32'h0, TE, 32'h0);
        acc(1'h1, TA, 32'h3F, TE, 32'h0);
        acc(1'h0, TA, 32'h0, TE, 32'h3F);
        acc(1'h1, TA, 32'h0, TE, 32'h0);
        acc(1'h1, 32'h10C00100, 32'h0, 64'h1, 32'h0);
        acc(1'h0, 32'h10C00100, 32'h0, 64'h1, 32'h0);
        acc(1'h0, 32'h10C001FC, 32'h0, 64'h8000000000000000, 32'h0);
        acc(1'h1, 32'h10C00200, 32'h0, 64'h0, 32'h0);
        acc(1'h0, 32'h10BFFFFC, 32'h0, 64'h0, 32'h0);
        $display("register test done");
        exp_q = '{2};
        acc(1'h1, TA, 32'h84, TE, 32'h0);
        acc(1'h1, TA, 32'h0, TE, 32'h0);
        repeat (60) if (exp_q.size() != 0) @(posedge i_clk);
        cmp("forced", 64'h0, exp_q.size());
        $display("forced test done");
        exp_q = '{5, 0, 0, 0, 0, 1, 2, 3, 4};
        req_add <= 6'h20;
        @(posedge i_clk);
        req_add <= 6'h3F;
        @(posedge i_clk);
        req_add <= 6'h00;
        repeat (300) if (exp_q.size() != 0) @(posedge i_clk);
        cmp("left", 64'h0, exp_q.size());
        cmp("starts", 64'h7, starts);
        $display("dma test done");
        test_done();
    end
endmodule
